// File: hdl/audio_rx_pkg.sv
// How it works
// - Receiver is slave; source makes both clocks
// - Frame clock, bit clock, one shared data line
// - Format code D3-D0, first-bit select D4
// - Reset: I2S framing, MSB first
// - First-bit select: 0 MSB, 1 LSB first
// - 32fs: 1100 I2S 15-bit, 1110 16-bit
// - I2S codes 0000/0100/1000 give 24/20/18 bits
// - Low bits 01 left, 10 right justified
// - Source bit clock is 32/48/64 fs
// - Bit 5 delays bit clock one core cycle
// - Bit 6 picks slot for channel one
// - Bit 7 picks slot for channel two, reset 1
// - Both channel selects act independently
`default_nettype none
package audio_rx_pkg;
   localparam logic [7:0] CFG_OFFSET     = 8'h01;
   localparam logic [7:0] STATUS_OFFSET  = 8'h02;
   localparam logic [7:0] CFG_RESET      = 8'h80;
   localparam int         FMT_LSB        = 0;
   localparam int         FIRST_BIT_POS  = 4;
   localparam int         BCLK_DELAY_POS = 5;
   localparam int         CH1_SEL_POS    = 6;
   localparam int         CH2_SEL_POS    = 7;
   localparam int         OVERRUN_POS    = 0;
   localparam int         NOT_EMPTY_POS  = 1;
   localparam logic [1:0] STYLE_I2S      = 2'h0;
   localparam logic [1:0] STYLE_LEFT     = 2'h1;
   localparam logic [1:0] STYLE_RIGHT    = 2'h2;
   localparam logic [1:0] RATIO_32       = 2'h0;
   localparam logic [1:0] RATIO_48       = 2'h1;
   localparam int         SAMPLE_W       = 24;
   localparam int         FIFO_DEPTH     = 16;
   localparam int         CORE_PERIOD_NS = 50;
   localparam int         LINK_HALF_NS   = 200;
   localparam int         LINK_HALF_CYCLES = (LINK_HALF_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;

   // Word length from the upper format bits
   function automatic logic [4:0] word_len(input logic [1:0] len_code);
      case (len_code)
         2'h0:    word_len = 5'h18;
         2'h1:    word_len = 5'h14;
         2'h2:    word_len = 5'h12;
         default: word_len = 5'h10;
      endcase
   endfunction
endpackage
`default_nettype wire

// File: hdl/audio_link_if.sv
`default_nettype none
interface audio_link_if;
   logic frame_clock_in;
   logic bit_clock_in;
   logic serial_data_in;

   modport source (
      output frame_clock_in,
      output bit_clock_in,
      output serial_data_in
   );
   modport receiver (
      input frame_clock_in,
      input bit_clock_in,
      input serial_data_in
   );
endinterface
`default_nettype wire

// File: hdl/sample_fifo.sv
`default_nettype none
module sample_fifo #(
   parameter int WIDTH = 48,
   parameter int DEPTH = 16
) (
   input  wire logic                     core_clk,
   input  wire logic                     rst_b,
   input  wire logic                     clk_en,
   input  wire logic                     in_valid,
   output logic                          in_ready,
   input  wire logic [WIDTH-1:0]         in_data,
   output logic                          out_valid,
   input  wire logic                     out_ready,
   output logic [WIDTH-1:0]              out_data
);
   localparam int PW = $clog2(DEPTH);
   localparam logic [PW:0] FULL_COUNT = (PW+1)'(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0]    wr_ptr;
   logic [PW-1:0]    rd_ptr;
   logic [PW:0]      count;
   wire              do_wr = in_valid & in_ready;
   wire              do_rd = out_valid & out_ready;

   assign in_ready  = count != FULL_COUNT;
   assign out_valid = count != '0;
   assign out_data  = mem[rd_ptr];

   always_ff @(posedge core_clk) begin
      if (clk_en && do_wr) begin
         mem[wr_ptr] <= in_data;
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else if (clk_en) begin
         if (do_wr) wr_ptr <= wr_ptr + 1'b1;
         if (do_rd) rd_ptr <= rd_ptr + 1'b1;
         if (do_wr && !do_rd) count <= count + 1'b1;
         else if (do_rd && !do_wr) count <= count - 1'b1;
      end
   end
endmodule
`default_nettype wire

// File: hdl/serial_audio_receiver.sv
`default_nettype none
module serial_audio_receiver
   import audio_rx_pkg::*;
(
   input  wire logic                core_clk,
   input  wire logic                rst_b,
   input  wire logic                clk_en,
   audio_link_if.receiver           link,
   input  wire logic [7:0]          reg_addr,
   input  wire logic [7:0]          reg_wdata,
   input  wire logic                reg_wr,
   input  wire logic                reg_rd,
   output logic [7:0]               reg_rdata,
   output logic                     sample_valid,
   input  wire logic                sample_ready,
   output logic [SAMPLE_W-1:0]      ch1_sample,
   output logic [SAMPLE_W-1:0]      ch2_sample
);
   logic [7:0]          cfg;
   logic                overrun;
   logic [2:0]          sync1;
   logic [2:0]          sync2;
   logic                bclk_late;
   logic                bclk_prev;
   logic                frame_prev;
   logic                started;
   logic [6:0]          bit_idx;
   logic [SAMPLE_W-1:0] shift_w;
   logic [4:0]          n_shift;
   logic [SAMPLE_W-1:0] left_word;
   logic                have_left;
   logic                push_valid;
   logic [2*SAMPLE_W-1:0] push_data;
   logic                push_ready;

   // Register fields
   wire [3:0] input_format_code  = cfg[FMT_LSB +: 4];
   wire [1:0] style              = input_format_code[1:0];
   wire [4:0] len                = word_len(input_format_code[3:2]);
   wire       first_bit_select   = cfg[FIRST_BIT_POS];
   wire       bit_clock_delay_en = cfg[BCLK_DELAY_POS];
   wire       ch1_slot_select    = cfg[CH1_SEL_POS];
   wire       ch2_slot_select    = cfg[CH2_SEL_POS];
   wire       i2s_like  = style != STYLE_LEFT && style != STYLE_RIGHT;

   // Link sampling, all three pins only listened to
   wire frame_bit = sync2[2];
   wire bclk_sync = sync2[1];
   wire data_bit  = sync2[0];
   wire bclk_now  = bit_clock_delay_en ? bclk_late : bclk_sync;
   wire bclk_rise = bclk_now & ~bclk_prev;
   wire boundary  = frame_bit != frame_prev;

   // Bit position inside the current slot
   wire [6:0]          idx    = boundary ? 7'h00 : bit_idx;
   wire [SAMPLE_W-1:0] base_w = boundary ? '0 : shift_w;
   wire [4:0]          base_n = boundary ? 5'h00 : n_shift;
   wire [6:0]          len7   = {2'h0, len};
   wire take_i2s  = idx >= 7'h01 && idx <= len7;
   wire take_left = idx < len7;
   wire take_bit  = style == STYLE_RIGHT ? 1'b1 : (style == STYLE_LEFT ? take_left : take_i2s);
   wire [SAMPLE_W-1:0] ins_w = first_bit_select ? {data_bit, base_w[SAMPLE_W-1:1]}
                                         : {base_w[SAMPLE_W-2:0], data_bit};
   wire [4:0] ins_n = base_n < len ? base_n + 5'h01 : base_n;

   // Finished slot, left-aligned with zero fill
   wire [4:0]          pad      = 5'h18 - n_shift;
   wire [SAMPLE_W-1:0] top_mask = ~({SAMPLE_W{1'b1}} >> n_shift);
   wire [SAMPLE_W-1:0] slot_word = first_bit_select ? (shift_w & top_mask) : (shift_w << pad);
   wire slot_is_left = i2s_like ? ~frame_prev : frame_prev;

   // Independent slot routing
   wire [SAMPLE_W-1:0] ch1_word = ch1_slot_select ? slot_word : left_word;
   wire [SAMPLE_W-1:0] ch2_word = ch2_slot_select ? slot_word : left_word;

   wire cfg_hit    = reg_addr == CFG_OFFSET;
   wire status_hit = reg_addr == STATUS_OFFSET;
   wire [7:0] status_val = {6'h00, sample_valid, overrun};
   wire [7:0] rd_mux = cfg_hit ? cfg : (status_hit ? status_val : 8'h00);
   wire overrun_set = push_valid & ~push_ready;
   wire overrun_clr = reg_wr & status_hit & reg_wdata[OVERRUN_POS];

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         cfg       <= CFG_RESET;
         reg_rdata <= 8'h00;
         overrun   <= 1'b0;
      end else if (clk_en) begin
         if (reg_wr && cfg_hit) cfg <= reg_wdata;
         reg_rdata <= reg_rd ? rd_mux : 8'h00;
         if (overrun_set) overrun <= 1'b1;
         else if (overrun_clr) overrun <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         sync1     <= 3'h0;
         sync2     <= 3'h0;
         bclk_late <= 1'b0;
         bclk_prev <= 1'b0;
      end else if (clk_en) begin
         sync1     <= {link.frame_clock_in, link.bit_clock_in, link.serial_data_in};
         sync2     <= sync1;
         bclk_late <= bclk_sync;
         bclk_prev <= bclk_now;
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         frame_prev <= 1'b0;
         started    <= 1'b0;
         bit_idx    <= 7'h00;
         shift_w    <= '0;
         n_shift    <= 5'h00;
      end else if (clk_en && bclk_rise) begin
         frame_prev <= frame_bit;
         if (boundary) started <= 1'b1;
         bit_idx    <= idx == 7'h7f ? idx : idx + 7'h01;
         shift_w    <= take_bit ? ins_w : base_w;
         n_shift    <= take_bit ? ins_n : base_n;
      end
   end

   // Pair the two slots of a frame into one entry
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         left_word  <= '0;
         have_left  <= 1'b0;
         push_valid <= 1'b0;
         push_data  <= '0;
      end else if (clk_en) begin
         push_valid <= 1'b0;
         if (bclk_rise && boundary && started) begin
            if (slot_is_left) begin
               left_word <= slot_word;
               have_left <= 1'b1;
            end else if (have_left) begin
               have_left  <= 1'b0;
               push_valid <= 1'b1;
               push_data  <= {ch2_word, ch1_word};
            end
         end
      end
   end

   sample_fifo #(
      .WIDTH (2*SAMPLE_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .core_clk  (core_clk),
      .rst_b     (rst_b),
      .clk_en    (clk_en),
      .in_valid  (push_valid),
      .in_ready  (push_ready),
      .in_data   (push_data),
      .out_valid (sample_valid),
      .out_ready (sample_ready),
      .out_data  ({ch2_sample, ch1_sample})
   );
endmodule
`default_nettype wire

// File: hdl/serial_audio_source.sv
`default_nettype none
module serial_audio_source
   import audio_rx_pkg::*;
(
   input  wire logic                core_clk,
   input  wire logic                rst_b,
   input  wire logic                clk_en,
   audio_link_if.source             link,
   input  wire logic [3:0]          format_code,
   input  wire logic                lsb_first,
   input  wire logic [1:0]          ratio_sel,
   input  wire logic                sample_valid,
   output logic                     sample_ready,
   input  wire logic [SAMPLE_W-1:0] left_sample,
   input  wire logic [SAMPLE_W-1:0] right_sample
);
   logic [3:0]          div;
   logic                bclk;
   logic                frame;
   logic                sdata;
   logic                slot;
   logic [5:0]          idx;
   logic [SAMPLE_W-1:0] cur_left;
   logic [SAMPLE_W-1:0] cur_right;

   wire [1:0] style    = format_code[1:0];
   wire       i2s_like = style != STYLE_LEFT && style != STYLE_RIGHT;
   wire [4:0] len      = word_len(format_code[3:2]);
   wire [5:0] slot_len = ratio_sel == RATIO_32 ? 6'h10 : (ratio_sel == RATIO_48 ? 6'h18 : 6'h20);
   wire       half_end = div == 4'(LINK_HALF_CYCLES - 1);
   wire       fall     = half_end & bclk;
   // Also ends a slot left too long by a ratio change
   wire       wrap     = idx >= slot_len - 6'h01;
   wire [5:0] next_idx = wrap ? 6'h00 : idx + 6'h01;
   wire       next_slot = wrap ? ~slot : slot;
   wire       load     = fall & wrap & slot;
   wire [SAMPLE_W-1:0] new_left = sample_valid ? left_sample : '0;
   wire [SAMPLE_W-1:0] src = next_slot ? cur_right : (load ? new_left : cur_left);
   wire [SAMPLE_W-1:0] word = src >> (5'h18 - len);

   // Bit position of the word carried at next_idx
   wire signed [7:0] pos_i2s = $signed({2'h0, next_idx}) - 8'sd1;
   wire signed [7:0] pos_rj  = $signed({2'h0, next_idx}) - $signed({2'h0, slot_len}) + $signed({3'h0, len});
   wire signed [7:0] pos = style == STYLE_RIGHT ? pos_rj :
                           (style == STYLE_LEFT ? $signed({2'h0, next_idx}) : pos_i2s);
   wire        in_word = pos >= 8'sd0 && pos < $signed({3'h0, len});
   wire [4:0]  pos5    = pos[4:0];
   wire [4:0]  msb_pos = len - 5'h01 - pos5;
   wire        bit_out = in_word & (lsb_first ? word[pos5] : word[msb_pos]);
   wire        frame_out = next_slot ? i2s_like : ~i2s_like;

   assign sample_ready = load;
   assign link.bit_clock_in   = bclk;
   assign link.frame_clock_in = frame;
   assign link.serial_data_in = sdata;

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         div <= 4'h0;
         bclk <= 1'b0;
      end else if (clk_en) begin
         div <= half_end ? 4'h0 : div + 4'h1;
         if (half_end) bclk <= ~bclk;
      end
   end

   // Frame and data change on the falling bit clock edge
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         frame     <= 1'b0;
         sdata     <= 1'b0;
         slot      <= 1'b1;
         idx       <= 6'h00;
         cur_left  <= '0;
         cur_right <= '0;
      end else if (clk_en && fall) begin
         idx   <= next_idx;
         slot  <= next_slot;
         // Frame level moves only at a slot end
         if (wrap) frame <= frame_out;
         sdata <= bit_out;
         if (load) begin
            cur_left  <= new_left;
            cur_right <= sample_valid ? right_sample : '0;
         end
      end
   end
endmodule
`default_nettype wire

// File: tb/audio_link_properties.sv
`default_nettype none
module audio_link_properties (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic frame_clock_in,
   input wire logic bit_clock_in,
   input wire logic serial_data_in
);
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (!rst_b);

   sequence s_high4;
      bit_clock_in [*4];
   endsequence
   sequence s_low4;
      !bit_clock_in [*4];
   endsequence

   property p_bclk_high;
      $rose(bit_clock_in) |-> s_high4 ##1 !bit_clock_in;
   endproperty
   property p_bclk_low;
      $fell(bit_clock_in) |-> s_low4 ##1 bit_clock_in;
   endproperty
   property p_frame_on_fall;
      $changed(frame_clock_in) |-> $fell(bit_clock_in);
   endproperty
   property p_data_on_fall;
      $changed(serial_data_in) |-> $fell(bit_clock_in);
   endproperty
   property p_data_held;
      $rose(bit_clock_in) |-> $stable(serial_data_in) [*4];
   endproperty
   property p_frame_held;
      bit_clock_in |-> $stable(frame_clock_in);
   endproperty
   property p_frame_min;
      $changed(frame_clock_in) |=> $stable(frame_clock_in) [*8];
   endproperty
   property p_frame_max;
      $changed(frame_clock_in) |-> ##[1:600] $changed(frame_clock_in);
   endproperty

   a_bclk_high: assert property (p_bclk_high)
      else $error("bit clock high phase wrong");
   a_bclk_low: assert property (p_bclk_low)
      else $error("bit clock low phase wrong");
   a_frame_on_fall: assert property (p_frame_on_fall)
      else $error("frame clock moved off falling edge");
   a_data_on_fall: assert property (p_data_on_fall)
      else $error("data moved off falling edge");
   a_data_held: assert property (p_data_held)
      else $error("data moved while bit clock high");
   a_frame_held: assert property (p_frame_held)
      else $error("frame moved while bit clock high");
   a_frame_min: assert property (p_frame_min)
      else $error("frame slot too short");
   a_frame_max: assert property (p_frame_max)
      else $error("frame slot too long");
endmodule
`default_nettype wire

// File: tb/serial_audio_input_receiver_test.sv
`default_nettype none
module serial_audio_input_receiver_test import audio_rx_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic        core_clk = 1'b0;
   logic        rst_b = 1'b0;
   logic [7:0]  reg_addr = 8'h00;
   logic [7:0]  reg_wdata = 8'h00;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic [7:0]  reg_rdata;
   logic        sample_valid;
   logic        sample_ready = 1'b0;
   logic [23:0] ch1_sample;
   logic [23:0] ch2_sample;
   logic [3:0]  format_code = 4'h0;
   logic        lsb_first = 1'b0;
   logic [1:0]  ratio_sel = 2'h2;
   logic [23:0] left_sample = 24'h000000;
   logic [23:0] right_sample = 24'h000000;
   logic [23:0] e1;
   logic [23:0] e2;
   logic [7:0]  cfg;
   logic [7:0]  d;
   logic [31:0] r;
   int          num_errors = 0;
   int          samples_checked = 0;
   int          seed = 3;
   int          n;
   logic        rx_run = 1'b1;
   logic [6:0]  fmt [15] = '{7'h40, 7'h24, 7'h58, 7'h0c, 7'h0e, 7'h21, 7'h45,
                             7'h59, 7'h4d, 7'h22, 7'h56, 7'h4a, 7'h5c, 7'h1d, 7'h23};

   audio_link_if link ();
   serial_audio_source serial_audio_source_i (.core_clk(core_clk), .rst_b(rst_b), .clk_en(1'b1), .link(link),
      .format_code(format_code), .lsb_first(lsb_first), .ratio_sel(ratio_sel), .sample_valid(1'b1),
      .sample_ready(), .left_sample(left_sample), .right_sample(right_sample));
   serial_audio_receiver serial_audio_receiver_i (.core_clk(core_clk), .rst_b(rst_b), .clk_en(rx_run), .link(link),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .sample_valid(sample_valid), .sample_ready(sample_ready), .ch1_sample(ch1_sample), .ch2_sample(ch2_sample));
   audio_link_properties audio_link_properties_i (.core_clk(core_clk), .rst_b(rst_b),
      .frame_clock_in(link.frame_clock_in), .bit_clock_in(link.bit_clock_in), .serial_data_in(link.serial_data_in));

   always #25 core_clk = ~core_clk;

   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic reg_write(input logic [7:0] a, input logic [7:0] w);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= w;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask

   task automatic reg_read(input logic [7:0] a, output logic [7:0] q);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      @(posedge core_clk);
      q = reg_rdata;
   endtask

   // Pops until empty, optionally comparing each pair
   task automatic drain(input bit chk, output int cnt);
      cnt = 0;
      for (int k = 0; k < 40; k++) begin
         @(negedge core_clk);
         if (sample_valid !== 1'b1)
            break;
         if (chk) begin
            check(ch1_sample, e1);
            check(ch2_sample, e2);
         end
         cnt++;
         @(posedge core_clk);
         sample_ready <= 1'b1;
         @(posedge core_clk);
         sample_ready <= 1'b0;
      end
      @(posedge core_clk);
   endtask

   // Expected word: cut to length, left-aligned, zero filled
   function automatic logic [23:0] trim(input logic [23:0] v, input logic [6:0] f);
      int len;
      int room;
      len = (f[3:2] == 2'h0) ? 24 : (f[3:2] == 2'h1) ? 20 : (f[3:2] == 2'h2) ? 18 : 16;
      room = (f[6:5] == 2'h0) ? 16 : (f[6:5] == 2'h1) ? 24 : 32;
      // I2S style spends the first slot bit as padding
      if (f[1] == f[0])
         room = room - 1;
      if (len > room)
         len = room;
      return v & (24'hffffff << (24 - len));
   endfunction

   initial begin
      #4000000;
      num_errors++;
      report_and_stop();
   end

   initial begin
      repeat (4) @(posedge core_clk);
      rst_b <= 1'b1;
      reg_read(CFG_OFFSET, d);
      check({16'h0000, d}, {16'h0000, CFG_RESET});
      reg_write(8'h07, 8'hff);
      reg_read(8'h07, d);
      check({16'h0000, d}, 24'h000000);
      // Write while frozen must not land
      rx_run <= 1'b0;
      reg_write(CFG_OFFSET, 8'h00);
      rx_run <= 1'b1;
      reg_read(CFG_OFFSET, d);
      check({16'h0000, d}, {16'h0000, CFG_RESET});
      $display("register test done");
      for (int i = 0; i < 15; i++) begin
         r = $random(seed);
         format_code <= fmt[i][3:0];
         lsb_first <= fmt[i][4];
         ratio_sel <= fmt[i][6:5];
         left_sample <= 24'($random(seed));
         right_sample <= 24'($random(seed));
         cfg = {r[1:0], r[2], fmt[i][4:0]};
         reg_write(8'h01, cfg);
         reg_read(8'h01, d);
         check({16'h0000, d}, {16'h0000, cfg});
         repeat (1600) @(posedge core_clk);
         drain(1'b0, n);
         e1 = trim(cfg[6] ? right_sample : left_sample, fmt[i]);
         e2 = trim(cfg[7] ? right_sample : left_sample, fmt[i]);
         repeat (1600) @(posedge core_clk);
         drain(1'b1, n);
         check({23'h000000, n >= 2}, 24'h000001);
         $display("format %h config %h done", fmt[i], cfg);
      end
      repeat (9000) @(posedge core_clk);
      @(link.frame_clock_in);
      repeat (8) @(posedge core_clk);
      reg_read(8'h02, d);
      check({16'h0000, d}, 24'h000003);
      drain(1'b1, n);
      check(24'(n), 24'h000010);
      reg_write(8'h02, 8'h01);
      reg_read(8'h02, d);
      check({16'h0000, d}, 24'h000000);
      $display("overrun test done");
      report_and_stop();
   end
endmodule
`default_nettype wire
